//--- core/prom_link_pkg.sv
`default_nettype none
package prom_link_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned POR_TIME_NS = 1000000;
  localparam int unsigned POR_CYC = POR_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned PULSE_MIN_NS = 300;
  localparam int unsigned PULSE_MAX_NS = 500;
  // least time rounds up, stays inside the max
  localparam int unsigned PULSE_CYC = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HOST_INIT_CYC = 4;
  localparam int unsigned HOST_HALF_CYC = 2;
  // ==========================================================
  // memory and command codes
  localparam int unsigned MEM_DEPTH = 256;
  localparam logic [7:0] RELOAD_CODE = 8'hEE;
  localparam logic PAR_MODE_RESET = 1'b0;
  localparam logic D4_ROUTE_RESET = 1'b0;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] BUS_PULL_LEVEL = 8'hFF;
endpackage
`default_nettype wire

//--- core/prom_link_if.sv
`default_nettype none
interface prom_link_if
  import prom_link_pkg::*;
;
  logic setup_clock;
  logic host_init_oe;
  logic dev_init_oe;
  logic init_n;
  logic chip_sel_n;
  logic [7:0] dev_data_o;
  logic [7:0] dev_data_oe;
  logic [7:0] data;
  logic chain_token_out_n;
  logic load_pulse_n;

  // ==========================================================
  // wire resolution: open-drain init with pull-up, pulled data bus
  assign init_n = ~(host_init_oe | dev_init_oe);
  assign data = (dev_data_o & dev_data_oe) | (BUS_PULL_LEVEL & ~dev_data_oe);

  modport device (
    input setup_clock,
    input init_n,
    input chip_sel_n,
    output dev_init_oe,
    output dev_data_o,
    output dev_data_oe,
    output chain_token_out_n,
    output load_pulse_n
  );

  modport target (
    output setup_clock,
    output host_init_oe,
    output chip_sel_n,
    input init_n,
    input data,
    input chain_token_out_n,
    input load_pulse_n
  );
endinterface
`default_nettype wire

//--- core/prom_target_end.sv
`default_nettype none
module prom_target_end
  import prom_link_pkg::*;
#(
  parameter int unsigned LEN_W = 16,
  parameter int unsigned HALF_CYC = HOST_HALF_CYC,
  parameter int unsigned INIT_CYC = HOST_INIT_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  prom_link_if.target link,
  input wire logic START_I,
  input wire logic PAR_MODE_I,
  input wire logic [LEN_W-1:0] LEN_I,
  output logic [7:0] RX_DATA_O,
  output logic RX_VALID_O,
  output logic DONE_O,
  output logic BUSY_O
);
  typedef enum logic [2:0] {IDLE, INIT, WAIT_READY, RUN, FINISHED} host_state_e;

  typedef struct packed {
    host_state_e state;
    logic [7:0] div_cnt;
    logic sclk;
    logic [7:0] init_cnt;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic [LEN_W-1:0] word_cnt;
    logic [LEN_W-1:0] len;
    logic [7:0] rx_data;
    logic rx_valid;
    logic done;
    logic cs_n;
    logic init_oe;
    logic par;
    logic load_prev;
  } host_s;

  host_s s;
  host_s next_s;
  logic [7:0] got;

  always_comb begin
    next_s = s;
    got = s.shift;
    next_s.rx_valid = 1'b0;
    next_s.load_prev = link.load_pulse_n;
    case (s.state)
      IDLE, FINISHED: begin
        next_s.sclk = 1'b0;
        // a reload pulse from the memory restarts loading like START_I
        if (START_I || (s.load_prev && !link.load_pulse_n)) begin
          next_s.init_oe = 1'b1;
          next_s.init_cnt = 8'h00;
          next_s.cs_n = 1'b0;
          next_s.done = 1'b0;
          next_s.par = PAR_MODE_I;
          next_s.len = LEN_I;
          next_s.state = INIT;
        end
      end
      INIT: begin
        next_s.init_cnt = s.init_cnt + 8'h01;
        if (s.init_cnt == 8'(INIT_CYC - 1)) begin
          next_s.init_oe = 1'b0;
          next_s.state = WAIT_READY;
        end
      end
      WAIT_READY: begin
        if (link.init_n) begin
          next_s.div_cnt = 8'h00;
          next_s.word_cnt = '0;
          next_s.bit_cnt = 3'h0;
          next_s.state = (s.len == '0) ? FINISHED : RUN;
          next_s.done = (s.len == '0);
          next_s.cs_n = (s.len == '0);
        end
      end
      RUN: begin
        next_s.div_cnt = s.div_cnt + 8'h01;
        if (s.div_cnt == 8'(HALF_CYC - 1)) begin
          next_s.div_cnt = 8'h00;
          next_s.sclk = ~s.sclk;
          if (!s.sclk) begin
            got = s.par ? link.data : {s.shift[6:0], link.data[0]};
            next_s.shift = got;
            next_s.bit_cnt = s.bit_cnt + 3'h1;
            if (s.par || s.bit_cnt == LAST_BIT) begin
              next_s.rx_data = got;
              next_s.rx_valid = 1'b1;
              next_s.bit_cnt = 3'h0;
              next_s.word_cnt = s.word_cnt + 1'b1;
              if (s.word_cnt + 1'b1 == s.len) begin
                next_s.done = 1'b1;
                next_s.cs_n = 1'b1;
                next_s.state = FINISHED;
              end
            end
          end
        end
      end
      default: next_s.state = IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s <= '{state: IDLE, cs_n: 1'b1, load_prev: 1'b1, default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign link.setup_clock = s.sclk;
  assign link.host_init_oe = s.init_oe;
  assign link.chip_sel_n = s.cs_n;
  assign RX_DATA_O = s.rx_data;
  assign RX_VALID_O = s.rx_valid;
  assign DONE_O = s.done;
  assign BUSY_O = (s.state != IDLE) && (s.state != FINISHED);
endmodule
`default_nettype wire

//--- core/prom_device_end.sv
// Function
// - advance address and bit on clock rise
// - stop past last address, float, token low
// - edge after last data hands token on
// - drive data only while select is low; the code also drives D4 low during a reload pulse with select high
// - only the token holder drives data; the code drives the D4 reload pulse whatever the token
// - init low or select high clears counter
// - select high means standby, outputs float; the code still drives D4 low during a reload pulse
// - init polarity fixed active low
// - hold init low about 1 ms after power
// - supply drop resets read state
// - reload command pulses load output 300-500 ns
// - control register picks serial or parallel
// - parallel mode gives one byte per clock
// - load pulse on D4 only when serial
// - target clocks and samples on rising edge
// - target ties init to every init pin
// - target may drive select from done
// - instruction 11101110 is the reload command
`default_nettype none
module prom_device_end
  import prom_link_pkg::*;
#(
  parameter int unsigned DEPTH = MEM_DEPTH,
  parameter int unsigned POR_CYCLES = POR_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  prom_link_if.device link,
  input wire logic POWER_GOOD_I,
  input wire logic PROG_WE_I,
  input wire logic [$clog2(DEPTH)-1:0] PROG_ADDR_I,
  input wire logic [7:0] PROG_DATA_I,
  input wire logic CTRL_WE_I,
  input wire logic CTRL_PAR_I,
  input wire logic CTRL_LOAD_ON_D4_I,
  input wire logic IR_VALID_I,
  input wire logic [7:0] IR_CODE_I,
  output logic PAR_MODE_O,
  output logic D4_ROUTE_O,
  output logic READY_O,
  output logic STANDBY_O,
  output logic [$clog2(DEPTH)-1:0] ADDR_O
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned POR_W = $clog2(POR_CYCLES + 1);
  localparam int unsigned PW = $clog2(PULSE_CYC + 1);
  localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH - 1);
  localparam logic [POR_W-1:0] POR_LAST = POR_W'(POR_CYCLES - 1);
  localparam logic [PW-1:0] PULSE_LOAD = PW'(PULSE_CYC);

  typedef struct packed {
    logic [POR_W-1:0] por_cnt;
    logic por_done;
    logic clk_prev;
    logic [AW-1:0] addr;
    logic [2:0] bit_idx;
    logic past_last;
    logic [7:0] data;
    logic drive;
    logic token_n;
    logic par_mode;
    logic d4_route;
    logic [PW-1:0] pulse_cnt;
    logic load_n;
  } dev_s;

  dev_s s;
  dev_s next_s;
  logic [7:0] mem [DEPTH];
  logic active;
  logic rise;
  logic at_last;
  logic [7:0] word;
  logic [7:0] data_out;
  logic [7:0] data_oe;

  // ==========================================================
  // stored bitstream
  // no reset on the array: it stands in for non-volatile cells
  always_ff @(posedge CORE_CLK_I) begin
    if (PROG_WE_I) begin
      mem[PROG_ADDR_I] <= PROG_DATA_I;
    end
  end

  assign word = mem[s.addr];

  // ==========================================================
  // read enable
  // init is always active low, no polarity option
  // init low or select high blocks reading
  // select high forces standby whatever init says
  assign active = s.por_done & POWER_GOOD_I & link.init_n & ~link.chip_sel_n;
  // pins are synchronous, so one flop of history is enough
  // limitation: a clock already high at select counts no edge until it falls
  assign rise = link.setup_clock & ~s.clk_prev;
  assign at_last = (s.addr == LAST_ADDR) && (s.par_mode || s.bit_idx == LAST_BIT);

  always_comb begin
    next_s = s;
    next_s.clk_prev = link.setup_clock;

    if (!POWER_GOOD_I) begin
      next_s.por_cnt = '0;
      next_s.por_done = 1'b0;
    end else if (!s.por_done) begin
      if (s.por_cnt == POR_LAST) begin
        next_s.por_done = 1'b1;
      end else begin
        next_s.por_cnt = s.por_cnt + 1'b1;
      end
    end

    if (CTRL_WE_I) begin
      next_s.par_mode = CTRL_PAR_I;
      next_s.d4_route = CTRL_LOAD_ON_D4_I & ~CTRL_PAR_I;
    end

    if (IR_VALID_I && IR_CODE_I == RELOAD_CODE && s.pulse_cnt == '0) begin
      next_s.pulse_cnt = PULSE_LOAD;
    end else if (s.pulse_cnt != '0) begin
      next_s.pulse_cnt = s.pulse_cnt - 1'b1;
    end
    next_s.load_n = (next_s.pulse_cnt == '0);

    if (!active) begin
      next_s.addr = '0;
      next_s.bit_idx = 3'h0;
      next_s.past_last = 1'b0;
    end else if (rise && !s.past_last) begin
      if (at_last) begin
        next_s.past_last = 1'b1;
      end else if (s.par_mode || s.bit_idx == LAST_BIT) begin
        next_s.addr = s.addr + 1'b1;
        next_s.bit_idx = 3'h0;
      end else begin
        next_s.bit_idx = s.bit_idx + 3'h1;
      end
    end

    // data one cycle after pointer
    // serial order is most significant bit first
    // data tracks the pointer even when idle, so the first bit is ready at select
    next_s.data = s.par_mode ? word : {7'h00, word[LAST_BIT - s.bit_idx]};
    next_s.drive = active & ~next_s.past_last;
    next_s.token_n = ~(active & next_s.past_last);
  end

  always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      s <= '{
        par_mode: PAR_MODE_RESET,
        d4_route: D4_ROUTE_RESET,
        clk_prev: 1'b0,
        token_n: 1'b1,
        load_n: 1'b1,
        default: '0
      };
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // pin drive
  always_comb begin
    data_out = s.data;
    data_oe = s.par_mode ? {8{s.drive}} : {7'h00, s.drive};
    // load pulse on D4
    // open-drain style: driven low only during the pulse
    // the pulse ignores the token, as it resets the target, not the stream
    if (s.d4_route && !s.par_mode) begin
      data_out[4] = 1'b0;
      data_oe[4] = ~s.load_n;
    end
  end

  assign link.dev_data_o = data_out;
  assign link.dev_data_oe = data_oe;
  assign link.chain_token_out_n = s.token_n;
  assign link.load_pulse_n = s.load_n;
  assign link.dev_init_oe = ~s.por_done;

  assign PAR_MODE_O = s.par_mode;
  assign D4_ROUTE_O = s.d4_route;
  assign READY_O = s.por_done;
  assign STANDBY_O = link.chip_sel_n;
  assign ADDR_O = s.addr;
endmodule
`default_nettype wire

//--- verif/prom_link_chk.sv
`default_nettype none
module prom_link_chk (
  input wire logic CORE_CLK_I,
  input wire logic RESET_N_I,
  input wire logic setup_clock,
  input wire logic init_n,
  input wire logic chip_sel_n,
  input wire logic dev_init_oe,
  input wire logic [7:0] dev_data_o,
  input wire logic [7:0] dev_data_oe,
  input wire logic chain_token_out_n,
  input wire logic load_pulse_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // ==========================================================
  // link checks
  inactive_idle_a: assert property (
    (!init_n || chip_sel_n)[*2] |-> chain_token_out_n && (dev_data_oe == 8'h00 || !load_pulse_n))
    else $error("inactive link still driving");
  token_float_a: assert property (
    !chain_token_out_n && load_pulse_n |-> dev_data_oe == 8'h00)
    else $error("data driven after token handed on");
  pulse_width_a: assert property (
    $fell(load_pulse_n) |-> !load_pulse_n[*3] ##1 load_pulse_n)
    else $error("reload pulse width wrong");
  data_step_a: assert property (
    dev_data_oe[0] && $past(dev_data_oe[0]) && (dev_data_o & 8'hEF) != $past(dev_data_o & 8'hEF)
    |-> $past(setup_clock, 2) && !$past(setup_clock, 3))
    else $error("data moved without a clock rise");
  init_hold_a: assert property (
    $fell(dev_init_oe) |-> $past(dev_init_oe, 7))
    else $error("init hold released early");
  sel_gate_a: assert property (
    dev_data_oe[0] |-> !$past(chip_sel_n) && $past(init_n))
    else $error("data driven while unselected");
  d4_route_a: assert property (
    dev_data_oe[4] && !dev_data_oe[5] |-> !load_pulse_n && !dev_data_o[4])
    else $error("d4 driven outside reload pulse");
  par_byte_a: assert property (
    dev_data_oe[1] |-> dev_data_oe[7:5] == 3'h7 && dev_data_oe[3:0] == 4'hF)
    else $error("partial byte enabled");
endmodule
`default_nettype wire

//--- verif/config_prom_sequential_read_bench.sv
`default_nettype none
module config_prom_sequential_read_bench
  import prom_link_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEP = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic pgood = 1'b1, prog_we = 1'b0, ctrl_we = 1'b0, ctrl_par = 1'b0, ctrl_d4 = 1'b0;
  logic ir_valid = 1'b0, start = 1'b0, par_i = 1'b0;
  logic [1:0] prog_addr = 2'h0;
  logic [7:0] prog_data = 8'h00, ir_code = 8'h00, rx_data;
  logic [15:0] len_i = 16'h0000;
  logic par_mode, d4_route, ready, standby, rx_valid, done, busy;
  logic [1:0] addr_o;
  logic [31:0] rng = 32'h0000_0035;
  logic [7:0] mem [DEP];
  logic [7:0] exp_q [$];
  logic tok_q [$];
  logic [7:0] codes [4] = '{8'hEE, 8'hEF, 8'h6E, 8'hFE};
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  always #50 clk = ~clk;
  prom_link_if link ();
  prom_device_end #(.DEPTH(DEP), .POR_CYCLES(8)) u_prom_device_end (
    .CORE_CLK_I(clk), .RESET_N_I(reset_n), .link(link), .POWER_GOOD_I(pgood),
    .PROG_WE_I(prog_we), .PROG_ADDR_I(prog_addr), .PROG_DATA_I(prog_data),
    .CTRL_WE_I(ctrl_we), .CTRL_PAR_I(ctrl_par), .CTRL_LOAD_ON_D4_I(ctrl_d4),
    .IR_VALID_I(ir_valid), .IR_CODE_I(ir_code), .PAR_MODE_O(par_mode),
    .D4_ROUTE_O(d4_route), .READY_O(ready), .STANDBY_O(standby), .ADDR_O(addr_o));
  prom_target_end u_prom_target_end (
    .CORE_CLK_I(clk), .RESET_N_I(reset_n), .link(link), .START_I(start), .PAR_MODE_I(par_i),
    .LEN_I(len_i), .RX_DATA_O(rx_data), .RX_VALID_O(rx_valid), .DONE_O(done), .BUSY_O(busy));
  prom_link_chk chk (
    .CORE_CLK_I(clk), .RESET_N_I(reset_n), .setup_clock(link.setup_clock),
    .init_n(link.init_n), .chip_sel_n(link.chip_sel_n), .dev_init_oe(link.dev_init_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe),
    .chain_token_out_n(link.chain_token_out_n), .load_pulse_n(link.load_pulse_n));
  // ==========================================================
  // helpers
  function automatic logic [7:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bounded wait: 0 for done, 1 for ready
  task automatic wait_for(input int what);
    n = 0;
    while (((what == 0) ? done : ready) !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    if (n == 3000) begin
      fail_count++;
      $display("ERROR t=%0t wait timed out", $time);
      final_report();
    end
  endtask
  task automatic ctrl(input logic p, input logic d);
    ctrl_par = p;
    ctrl_d4 = d;
    ctrl_we = 1'b1;
    tick();
    ctrl_we = 1'b0;
    tick();
  endtask
  // words past the last address read as the pulled bus
  task automatic read_run(input logic par, input int len);
    par_i = par;
    len_i = 16'(len);
    for (int i = 0; i < len; i++) begin
      exp_q.push_back(i < DEP ? mem[i] : 8'hFF);
      tok_q.push_back(i < DEP);
    end
    start = 1'b1;
    tick();
    chk_flag(busy, 1'b1);
    start = 1'b0;
    tick();
    wait_for(0);
    tick(3);
    chk_byte(8'(exp_q.size()), 8'h00);
    chk_flag(link.chain_token_out_n, 1'b1);
    chk_flag(standby, 1'b1);
    chk_byte({6'h00, addr_o}, 8'h00);
    chk_flag(busy, 1'b0);
  endtask
  // unexpected words get a mismatching reference
  always @(negedge clk) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back(~rx_data);
      if (tok_q.size() == 0) tok_q.push_back(~link.chain_token_out_n);
      chk_byte(rx_data, exp_q.pop_front());
      chk_flag(link.chain_token_out_n, tok_q.pop_front());
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    tick(6);
    reset_n = 1'b1;
    chk_flag(par_mode, 1'b0);
    chk_flag(d4_route, 1'b0);
    wait_for(1);
    tick();
    chk_flag(link.init_n, 1'b1);
    for (int i = 0; i < DEP; i++) begin
      mem[i] = xs();
      prog_we = 1'b1;
      prog_addr = 2'(i);
      prog_data = mem[i];
      tick();
    end
    prog_we = 1'b0;
    read_run(1'b0, DEP + 1);
    $display("serial read finished");
    ctrl(1'b1, 1'b0);
    chk_flag(par_mode, 1'b1);
    read_run(1'b1, DEP + 1);
    $display("parallel read finished");
    len_i = 16'h0000;
    for (int r = 0; r < 2; r++) begin
      ctrl(1'b0, r[0]);
      chk_flag(d4_route, r[0]);
      foreach (codes[c]) begin
        ir_code = codes[c];
        ir_valid = 1'b1;
        tick();
        ir_valid = 1'b0;
        n = 0;
        repeat (8) begin
          if (link.load_pulse_n === 1'b0) n++;
          if (link.load_pulse_n === 1'b0 && r == 1) chk_flag(link.data[4], 1'b0);
          tick();
        end
        chk_byte(8'(n), (codes[c] == RELOAD_CODE) ? 8'(PULSE_CYC) : 8'h00);
        tick(12);
      end
    end
    ctrl(1'b1, 1'b1);
    chk_flag(d4_route, 1'b0);
    ctrl(1'b0, 1'b0);
    $display("reload finished");
    pgood = 1'b0;
    tick(2);
    chk_flag(link.init_n, 1'b0);
    chk_flag(ready, 1'b0);
    pgood = 1'b1;
    wait_for(1);
    tick();
    chk_flag(link.init_n, 1'b1);
    read_run(1'b0, 2);
    $display("power drop finished");
    final_report();
  end
endmodule
`default_nettype wire
